// File: design/gwcpc_ctrl.sv
/*
  gauge housekeeping controller: wake comparator, flash write gate, offset
  autocalibration, profile selection on insertion and application status.
  assumes measurements arrive synchronous to clk with a valid strobe per
  reading; the command engine presents a command code and takes read data.
*/
`timescale 1ns/1ps
`include "gwcpc_defines.svh"

module gwcpc_ctrl #(
  parameter int  VW        = 16,
  parameter int  PW        = 16,
  parameter int  CAL_CYC   = 1000,
  parameter int  Z_TOL     = 16,
  parameter longint TEMP_HOLD_CYC = `GWCPC_TEMP_HOLD_CYC
) (
  // clock
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       clk_en,
  // configuration
  input  wire gwcpc_pkg::gwcpc_wake_cfg_t wake_cfg,
  input  wire logic [15:0]                flash_ok_mv,
  input  wire logic [15:0]                sleep_ma,
  // measurements
  input  wire gwcpc_pkg::gwcpc_meas_t     meas,
  input  wire logic                       meas_valid,
  input  wire logic signed [VW-1:0]       sense_pos_in,
  input  wire logic signed [VW-1:0]       sense_neg_in,
  input  wire logic signed [VW-1:0]       rate_in,
  // sleep
  input  wire logic                       sleep_entry,
  output logic                            sleeping,
  output logic                            wake_irq,
  // calibration
  output logic                            cal_busy,
  output logic                            cal_aborted,
  output logic signed [VW-1:0]            sense_corr,
  output logic signed [VW-1:0]            rate_out,
  // flash
  input  wire logic                       nv_wr_req,
  output logic                            nv_wr_en,
  // insertion and profiles
  input  wire logic                       pack_inserted,
  input  wire logic [15:0]                open_circuit_voltage,
  input  wire logic                       ocv_ready,
  input  wire logic                       ocv_bad,
  input  wire logic [7:0]                 soc_lookup,
  input  wire logic [PW-1:0]              meas_z,
  input  wire logic                       def_wr,
  input  wire logic [PW-1:0]              def_data,
  input  wire logic                       prof_upd_wr,
  input  wire logic [PW-1:0]              prof_upd_data,
  output logic [PW-1:0]                   active_prof,
  output logic [7:0]                      soc,
  output logic                            battery_good_out_n,
  output gwcpc_pkg::gwcpc_init_flags_t    init_flags,
  // command read
  input  wire logic                       cmd_rd,
  input  wire logic [7:0]                 cmd_code,
  output logic [7:0]                      cmd_rdata,
  output logic                            cmd_ack,
  output logic                            cmd_nack
);

  typedef enum logic [2:0] {
    INS_IDLE,
    INS_OCV,
    INS_SOC,
    INS_IMP,
    INS_DONE
  } gwcpc_ins_t;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN
  } gwcpc_cal_t;

  // sleep and wake
  logic sleep_q, sleep_d;
  logic wake_raw;

  // calibration
  gwcpc_cal_t         cal_q, cal_d;
  logic [31:0]        cal_cnt_q, cal_cnt_d;
  logic signed [VW-1:0] ofs_q, ofs_d;
  logic signed [VW-1:0] ofs_acc_q, ofs_acc_d;
  logic signed [VW-1:0] rate_q, rate_d;
  logic [15:0]        cal_v_q, cal_v_d;
  logic [15:0]        cal_t_q, cal_t_d;
  logic [15:0]        start_v_q, start_v_d;
  logic [63:0]        tdrift_q, tdrift_d;
  logic               abort_q, abort_d;
  logic signed [VW-1:0] raw_sense;

  // insertion
  gwcpc_ins_t         ins_q, ins_d;
  logic               bgood_q, bgood_d;
  gwcpc_pkg::gwcpc_init_flags_t flags_q, flags_d;
  logic [7:0]         soc_q, soc_d;
  logic               commit;
  gwcpc_pkg::gwcpc_match_t match;
  logic               used_b;

  // command read
  logic [7:0]         rdata_q, rdata_d;
  logic               ack_q, ack_d;
  logic               nack_q, nack_d;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic temp_ok(input logic [15:0] t);
    temp_ok = ($signed(t) > `GWCPC_CAL_TEMP_LO) && ($signed(t) < `GWCPC_CAL_TEMP_HI);
  endfunction

  assign raw_sense = VW'(sense_pos_in - sense_neg_in);

  gwcpc_wake_cmp #(
    .VW (VW)
  ) u_wake (
    .clk      (clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .cfg      (wake_cfg),
    .sleeping (sleep_q),
    .sense_uv (sense_corr),
    .wake_irq (wake_raw)
  );

  gwcpc_profile_store #(
    .PW  (PW),
    .TOL (Z_TOL)
  ) u_prof (
    .clk         (clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .def_wr      (def_wr),
    .def_data    (def_data),
    .meas_z      (meas_z),
    .match       (match),
    .commit      (commit),
    .upd_wr      (prof_upd_wr),
    .upd_data    (prof_upd_data),
    .used_b      (used_b),
    .active_prof (active_prof)
  );

  // sleep state
  always_comb begin
    sleep_d = sleep_q;
    if (!sleep_q && sleep_entry) begin
      sleep_d = 1'b1;
    end else if (sleep_q && (wake_raw || ($signed(meas.avg_ma) > $signed(sleep_ma)))) begin
      sleep_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else if (clk_en) begin
      sleep_q <= sleep_d;
    end
  end

  // offset calibration
  always_comb begin
    logic trig;
    trig      = 1'b0;
    cal_d     = cal_q;
    cal_cnt_d = cal_cnt_q;
    ofs_d     = ofs_q;
    ofs_acc_d = ofs_acc_q;
    rate_d    = rate_q;
    cal_v_d   = cal_v_q;
    cal_t_d   = cal_t_q;
    start_v_d = start_v_q;
    tdrift_d  = tdrift_q;
    abort_d   = 1'b0;
    if (absdiff(meas.temp_c, cal_t_q) > `GWCPC_CAL_TEMP_STEP) begin
      if (tdrift_q < TEMP_HOLD_CYC) begin
        tdrift_d = tdrift_q + 64'd1;
      end
    end else begin
      tdrift_d = '0;
    end
    if (!sleep_q && sleep_entry && temp_ok(meas.temp_c)) begin
      trig = 1'b1;
    end
    if ($signed(meas.avg_ma) <= `GWCPC_CAL_CURR_MAX &&
        (absdiff(meas.cell_mv, cal_v_q) >= `GWCPC_CAL_VOLT_STEP ||
         tdrift_q >= TEMP_HOLD_CYC)) begin
      trig = 1'b1;
    end
    unique case (cal_q)
      CAL_IDLE: begin
        rate_d = rate_in;
        if (trig) begin
          cal_d     = CAL_RUN;
          cal_cnt_d = '0;
          ofs_acc_d = raw_sense;
          start_v_d = meas.cell_mv;
        end
      end
      CAL_RUN: begin
        cal_cnt_d = cal_cnt_q + 32'd1;
        // a drop means load current rose, so the offset reading is stale
        if (meas_valid && start_v_q > meas.cell_mv &&
            (start_v_q - meas.cell_mv) > `GWCPC_CAL_ABORT_DROP) begin
          cal_d   = CAL_IDLE;
          abort_d = 1'b1;
        end else if (cal_cnt_q >= 32'(CAL_CYC - 1)) begin
          cal_d    = CAL_IDLE;
          ofs_d    = ofs_acc_q;
          cal_v_d  = meas.cell_mv;
          cal_t_d  = meas.temp_c;
          tdrift_d = '0;
        end
      end
      default: cal_d = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cal_q     <= CAL_IDLE;
      cal_cnt_q <= '0;
      ofs_q     <= '0;
      ofs_acc_q <= '0;
      rate_q    <= '0;
      cal_v_q   <= '0;
      cal_t_q   <= '0;
      start_v_q <= '0;
      tdrift_q  <= '0;
      abort_q   <= 1'b0;
    end else if (clk_en) begin
      cal_q     <= cal_d;
      cal_cnt_q <= cal_cnt_d;
      ofs_q     <= ofs_d;
      ofs_acc_q <= ofs_acc_d;
      rate_q    <= rate_d;
      cal_v_q   <= cal_v_d;
      cal_t_q   <= cal_t_d;
      start_v_q <= start_v_d;
      tdrift_q  <= tdrift_d;
      abort_q   <= abort_d;
    end
  end

  assign cal_busy    = (cal_q == CAL_RUN);
  assign cal_aborted = abort_q;
  assign sense_corr  = VW'(raw_sense - ofs_q);
  assign rate_out    = rate_q;
  assign nv_wr_en    = nv_wr_req && (meas.cell_mv >= flash_ok_mv);

  // insertion sequence
  always_comb begin
    ins_d   = ins_q;
    bgood_d = bgood_q;
    flags_d = flags_q;
    soc_d   = soc_q;
    commit  = 1'b0;
    unique case (ins_q)
      INS_IDLE: begin
        bgood_d = 1'b0;
        if (pack_inserted) begin
          ins_d   = INS_OCV;
          flags_d = '0;
        end
      end
      INS_OCV: begin
        if (ocv_ready) begin
          flags_d.ocv_done_flag    = 1'b1;
          flags_d.ocv_invalid_flag = ocv_bad;
          ins_d = INS_SOC;
        end
      end
      INS_SOC: begin
        soc_d   = soc_lookup;
        bgood_d = 1'b1;
        ins_d   = INS_IMP;
      end
      INS_IMP: begin
        commit = 1'b1;
        ins_d  = INS_DONE;
      end
      INS_DONE: begin
        flags_d.init_done_flag = 1'b1;
        if (!pack_inserted) begin
          ins_d = INS_IDLE;
        end
      end
      default: ins_d = INS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ins_q   <= INS_IDLE;
      bgood_q <= 1'b0;
      flags_q <= '0;
      soc_q   <= '0;
    end else if (clk_en) begin
      ins_q   <= ins_d;
      bgood_q <= bgood_d;
      flags_q <= flags_d;
      soc_q   <= soc_d;
    end
  end

  assign battery_good_out_n = ~bgood_q;
  assign init_flags         = flags_q;
  assign soc                = soc_q;
  assign sleeping           = sleep_q;
  assign wake_irq           = wake_raw;

  // status byte read; unknown codes answer with nack
  always_comb begin
    rdata_d = rdata_q;
    ack_d   = 1'b0;
    nack_d  = 1'b0;
    if (cmd_rd) begin
      if (cmd_code == `GWCPC_CMD_APP_STATUS) begin
        rdata_d = `GWCPC_STATUS_RESET;
        rdata_d[`GWCPC_STATUS_LAST_BIT] = used_b;
        ack_d = 1'b1;
      end else begin
        nack_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= `GWCPC_STATUS_RESET;
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      nack_q  <= nack_d;
    end
  end

  assign cmd_rdata = rdata_q;
  assign cmd_ack   = ack_q;
  assign cmd_nack  = nack_q;

endmodule

// File: design/gwcpc_defines.svh
/*
  constants for the gauge housekeeping controller: command code, status
  layout, threshold codes, calibration limits and timing counts.
  assumes a 200 mhz clock and units of mv, ma, uv and degrees c on inputs.
*/
`ifndef GWCPC_DEFINES_SVH
`define GWCPC_DEFINES_SVH

`define GWCPC_CMD_APP_STATUS    8'h6a
`define GWCPC_STATUS_LAST_BIT   0
`define GWCPC_STATUS_RESET      8'h00

// wake thresholds in microvolts
`define GWCPC_WAKE_TH_1         16'd1000
`define GWCPC_WAKE_TH_2         16'd2200
`define GWCPC_WAKE_TH_3         16'd4600
`define GWCPC_WAKE_TH_4         16'd9800

`define GWCPC_CAL_TEMP_LO       16'sd5
`define GWCPC_CAL_TEMP_HI       16'sd45
`define GWCPC_CAL_CURR_MAX      16'sd100
`define GWCPC_CAL_VOLT_STEP     16'd256
`define GWCPC_CAL_TEMP_STEP     16'd8
`define GWCPC_CAL_ABORT_DROP    16'd32

`define GWCPC_CLK_MHZ           200
`define GWCPC_TEMP_HOLD_S       60
`define GWCPC_TEMP_HOLD_CYC     (`GWCPC_TEMP_HOLD_S * `GWCPC_CLK_MHZ * 64'd1000000)

`endif

// File: design/gwcpc_pkg.sv
/*
  types shared by the gauge housekeeping controller.
  assumes the defines header is included by the files that need numbers.
*/
package gwcpc_pkg;

  typedef struct packed {
    logic        sense_sel_hi;
    logic        sense_sel_lo;
    logic        wake_range_sel;
  } gwcpc_wake_cfg_t;

  typedef struct packed {
    logic [15:0] cell_mv;
    logic [15:0] temp_c;
    logic [15:0] avg_ma;
  } gwcpc_meas_t;

  typedef struct packed {
    logic        ocv_done_flag;
    logic        ocv_invalid_flag;
    logic        init_done_flag;
  } gwcpc_init_flags_t;

  typedef enum logic [1:0] {
    GWCPC_SLOT_NONE,
    GWCPC_SLOT_A,
    GWCPC_SLOT_B
  } gwcpc_match_t;

endpackage

// File: design/gwcpc_profile_store.sv
/*
  profile store: two default slots, two dynamic pack slots with age tracking.
  assumes one profile word per slot; search result is combinational.
*/
`timescale 1ns/1ps

module gwcpc_profile_store #(
  parameter int PW = 16,
  parameter int TOL = 16
) (
  // clock
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  // default load
  input  wire logic          def_wr,
  input  wire logic [PW-1:0] def_data,
  // search and update
  input  wire logic [PW-1:0] meas_z,
  output gwcpc_pkg::gwcpc_match_t match,
  input  wire logic          commit,
  input  wire logic          upd_wr,
  input  wire logic [PW-1:0] upd_data,
  // state
  output logic               used_b,
  output logic [PW-1:0]      active_prof
);

  logic [PW-1:0] slot_q [4];
  logic [PW-1:0] slot_d [4];
  logic          valid_q [2];
  logic          valid_d [2];
  logic          older_b_q;
  logic          older_b_d;
  logic          cur_b_q;
  logic          cur_b_d;

  function automatic logic near(input logic [PW-1:0] a, input logic [PW-1:0] b);
    near = ((a > b) ? (a - b) : (b - a)) <= PW'(TOL);
  endfunction

  always_comb begin
    // only the dynamic slots are searched; a matches before b
    match = gwcpc_pkg::GWCPC_SLOT_NONE;
    if (valid_q[0] && near(meas_z, slot_q[2])) begin
      match = gwcpc_pkg::GWCPC_SLOT_A;
    end else if (valid_q[1] && near(meas_z, slot_q[3])) begin
      match = gwcpc_pkg::GWCPC_SLOT_B;
    end
  end

  always_comb begin
    slot_d    = slot_q;
    valid_d   = valid_q;
    older_b_d = older_b_q;
    cur_b_d   = cur_b_q;
    if (def_wr) begin
      slot_d[0] = def_data;
      slot_d[1] = def_data;
    end
    if (commit) begin
      unique case (match)
        gwcpc_pkg::GWCPC_SLOT_A: cur_b_d = 1'b0;
        gwcpc_pkg::GWCPC_SLOT_B: cur_b_d = 1'b1;
        gwcpc_pkg::GWCPC_SLOT_NONE: begin
          // new pack overwrites the older dynamic slot
          cur_b_d = older_b_q;
          slot_d[older_b_q ? 3 : 2] = slot_q[0];
          valid_d[older_b_q ? 1 : 0] = 1'b1;
        end
      endcase
      older_b_d = ~cur_b_d;
    end else if (upd_wr) begin
      slot_d[cur_b_q ? 3 : 2] = upd_data;
    end
  end

  // slots are never cleared on removal, only by reset
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        slot_q[i] <= '0;
      end
      valid_q[0] <= 1'b0;
      valid_q[1] <= 1'b0;
      older_b_q  <= 1'b0;
      cur_b_q    <= 1'b0;
    end else if (clk_en) begin
      slot_q    <= slot_d;
      valid_q   <= valid_d;
      older_b_q <= older_b_d;
      cur_b_q   <= cur_b_d;
    end
  end

  assign used_b      = cur_b_q;
  assign active_prof = slot_q[cur_b_q ? 3 : 2];

endmodule

// File: design/gwcpc_wake_cmp.sv
/*
  wake comparator: magnitude of signed sense voltage against decoded threshold.
  assumes sense voltage in microvolts, already offset-corrected.
*/
`timescale 1ns/1ps
`include "gwcpc_defines.svh"

module gwcpc_wake_cmp #(
  parameter int VW = 16
) (
  // clock
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  // inputs
  input  wire gwcpc_pkg::gwcpc_wake_cfg_t cfg,
  input  wire logic                     sleeping,
  input  wire logic signed [VW-1:0]     sense_uv,
  // output
  output logic                          wake_irq
);

  logic          wake_q;
  logic          wake_d;
  logic [VW-1:0] th;
  logic [VW-1:0] mag;

  function automatic logic [VW-1:0] decode_th(input gwcpc_pkg::gwcpc_wake_cfg_t c);
    case ({c.sense_sel_hi, c.sense_sel_lo, c.wake_range_sel})
      3'b010:         decode_th = VW'(`GWCPC_WAKE_TH_1);
      3'b011, 3'b100: decode_th = VW'(`GWCPC_WAKE_TH_2);
      3'b101, 3'b110: decode_th = VW'(`GWCPC_WAKE_TH_3);
      3'b111:         decode_th = VW'(`GWCPC_WAKE_TH_4);
      default:        decode_th = '0;
    endcase
  endfunction

  always_comb begin
    th     = decode_th(cfg);
    mag    = sense_uv[VW-1] ? VW'(-sense_uv) : sense_uv;
    wake_d = 1'b0;
    if (sleeping && (cfg.sense_sel_hi || cfg.sense_sel_lo)) begin
      wake_d = (mag > th);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_q <= 1'b0;
    end else if (clk_en) begin
      wake_q <= wake_d;
    end
  end

  assign wake_irq = wake_q;

endmodule

// File: test/gwcpc_ctrl_asserts.sv
/*
  concurrent checks on the ports of the gauge housekeeping controller.
  assumes one clock domain, synchronous active-high reset, bound below.
*/
`timescale 1ns/1ps

module gwcpc_ctrl_asserts #(
  parameter int VW = 16
) (
  // clock
  input wire logic                         clk,
  input wire logic                         reset,
  input wire logic                         clk_en,
  // inputs
  input wire gwcpc_pkg::gwcpc_wake_cfg_t   wake_cfg,
  input wire logic [15:0]                  flash_ok_mv,
  input wire gwcpc_pkg::gwcpc_meas_t       meas,
  input wire logic                         meas_valid,
  input wire logic                         nv_wr_req,
  input wire logic                         cmd_rd,
  input wire logic [7:0]                   cmd_code,
  // outputs
  input wire logic                         sleeping,
  input wire logic                         wake_irq,
  input wire logic                         cal_busy,
  input wire logic                         cal_aborted,
  input wire logic signed [VW-1:0]         sense_corr,
  input wire logic signed [VW-1:0]         rate_out,
  input wire logic                         nv_wr_en,
  input wire logic                         battery_good_out_n,
  input wire gwcpc_pkg::gwcpc_init_flags_t init_flags,
  input wire logic [7:0]                   cmd_rdata,
  input wire logic                         cmd_ack,
  input wire logic                         cmd_nack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  cmd_ack_a: assert property (
    cmd_rd && clk_en && cmd_code == 8'h6a |=> cmd_ack && !cmd_nack && cmd_rdata[7:1] == 7'h00)
    else $error("status read not answered");
  cmd_nack_a: assert property (
    cmd_rd && clk_en && cmd_code != 8'h6a |=> cmd_nack && !cmd_ack && $stable(cmd_rdata))
    else $error("unknown code not refused");
  flash_gate_a: assert property (
    nv_wr_en == (nv_wr_req && meas.cell_mv >= flash_ok_mv))
    else $error("flash write gate wrong");
  wake_off_a: assert property (
    clk_en && !wake_cfg.sense_sel_hi && !wake_cfg.sense_sel_lo |=> !wake_irq)
    else $error("wake raised while disabled");
  wake_top_a: assert property (
    clk_en && sleeping && wake_cfg == 3'b111 && sense_corr <= 16'sh2648
    && sense_corr >= -16'sh2648 |=> !wake_irq)
    else $error("wake below top threshold");
  wake_low_a: assert property (
    clk_en && sleeping && wake_cfg == 3'b010
    && (sense_corr > 16'sh03e8 || sense_corr < -16'sh03e8) |=> wake_irq)
    else $error("wake missed beyond low threshold");
  wake_asleep_a: assert property (
    wake_irq |-> $past(sleeping))
    else $error("wake while awake");
  sleep_exit_a: assert property (
    clk_en && sleeping && wake_irq |=> !sleeping)
    else $error("sleep kept after wake");
  cal_abort_a: assert property (
    cal_aborted |-> $past(cal_busy) && $past(meas_valid))
    else $error("abort without running calibration");
  cal_hold_a: assert property (
    cal_busy && $past(cal_busy) |-> $stable(rate_out))
    else $error("rate moved during calibration");
  good_ocv_a: assert property (
    !battery_good_out_n |-> init_flags.ocv_done_flag)
    else $error("battery good before voltage done");
  init_seq_a: assert property (
    $rose(init_flags.ocv_done_flag) |-> ##1 !battery_good_out_n ##2 init_flags.init_done_flag)
    else $error("insertion sequence out of step");
endmodule

bind gwcpc_ctrl gwcpc_ctrl_asserts #(.VW(VW)) gwcpc_ctrl_asserts_i (
  .clk(clk), .reset(reset), .clk_en(clk_en), .wake_cfg(wake_cfg),
  .flash_ok_mv(flash_ok_mv), .meas(meas), .meas_valid(meas_valid), .nv_wr_req(nv_wr_req),
  .cmd_rd(cmd_rd), .cmd_code(cmd_code), .sleeping(sleeping), .wake_irq(wake_irq),
  .cal_busy(cal_busy), .cal_aborted(cal_aborted), .sense_corr(sense_corr),
  .rate_out(rate_out), .nv_wr_en(nv_wr_en), .battery_good_out_n(battery_good_out_n),
  .init_flags(init_flags), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack)
);

// File: test/gwcpc_host_model.sv
/*
  host processor reading gauge commands, one byte per read.
  assumes the bench calls host_read only after reset is released.
*/
`timescale 1ns/1ps

module gwcpc_host_model (
  // clock
  input wire logic       clk,
  // command
  output logic           cmd_rd,
  output logic [7:0]     cmd_code,
  input wire logic       cmd_ack,
  input wire logic       cmd_nack,
  input wire logic [7:0] cmd_rdata
);
  initial begin
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
  end

  // gap gives a slow host; the answer is taken one cycle after the request edge
  task automatic host_read(input logic [7:0] code, input int gap, output logic ack,
                           output logic nack, output logic [7:0] data);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    @(posedge clk);
    ack = cmd_ack;
    nack = cmd_nack;
    data = cmd_rdata;
  endtask
endmodule

// File: test/testbench.sv
/*
  self-checking bench for the gauge housekeeping controller.
  assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps

module testbench;
  logic                         clk, reset, clk_en, meas_valid, sleep_entry, nv_wr_req;
  logic                         pack_inserted, ocv_ready, ocv_bad, def_wr, prof_upd_wr;
  logic [15:0]                  flash_ok_mv, sleep_ma, open_circuit_voltage, meas_z;
  logic [15:0]                  def_data, prof_upd_data, active_prof;
  logic signed [15:0]           sense_pos_in, sense_neg_in, rate_in, sense_corr, rate_out;
  logic [7:0]                   soc_lookup, soc, cmd_code, cmd_rdata, r_data;
  logic                         sleeping, wake_irq, cal_busy, cal_aborted, nv_wr_en;
  logic                         battery_good_out_n, cmd_rd, cmd_ack, cmd_nack;
  logic                         r_ack, r_nack, hit;
  gwcpc_pkg::gwcpc_wake_cfg_t   wake_cfg;
  gwcpc_pkg::gwcpc_meas_t       meas;
  gwcpc_pkg::gwcpc_init_flags_t init_flags;
  int                           errors, comparisons;
  localparam logic [15:0] TH [8] = '{16'h0000, 16'h0000, 16'h03e8, 16'h0898,
                                     16'h0898, 16'h11f8, 16'h11f8, 16'h2648};
  localparam logic [15:0] TEMPS [4] = '{16'h0005, 16'h0006, 16'h002c, 16'h002d};

  // short counts keep the run brief
  // every port has a bench signal of the same name and type
  gwcpc_ctrl #(.CAL_CYC(8), .TEMP_HOLD_CYC(50)) gwcpc_ctrl_i (.*);
  gwcpc_host_model gwcpc_host_model_i (.*);

  always #2.5 clk = ~clk;

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return sleeping;
      1: return cal_busy;
      2: return init_flags.init_done_flag;
      3: return wake_irq;
      default: return cal_aborted;
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic val);
    for (int i = 0; i < 60; i++) begin
      if (pick(sel) === val) return;
      @(posedge clk);
    end
    chk({15'h0000, pick(sel)}, {15'h0000, val});
    finish_test();
  endtask

  // wake and abort are short pulses, so collect them over a window
  task automatic seen(input int sel, input int n, input logic exp);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      hit |= pick(sel);
    end
    chk({15'h0000, hit}, {15'h0000, exp});
  endtask

  task automatic read_cmd(input logic [7:0] code, input int gap, input logic ack,
                          input logic [7:0] data);
    gwcpc_host_model_i.host_read(code, gap, r_ack, r_nack, r_data);
    chk({14'h0000, r_ack, r_nack}, {14'h0000, ack, !ack});
    chk({8'h00, r_data}, {8'h00, data});
  endtask

  task automatic sleep_in(input logic [15:0] raw);
    sense_pos_in <= raw;
    sense_neg_in <= 16'sh0000;
    @(posedge clk);
    sleep_entry <= 1'b1;
    @(posedge clk);
    sleep_entry <= 1'b0;
  endtask

  task automatic wake_up();
    meas.avg_ma <= 16'h003c;
    @(posedge clk);
    wait_for(0, 1'b0);
    meas.avg_ma <= 16'h000a;
    wait_for(1, 1'b0);
  endtask

  task automatic drive(input logic neg_dir, input logic [15:0] v);
    sense_pos_in <= neg_dir ? 16'sh0000 : v;
    sense_neg_in <= neg_dir ? v : 16'sh0000;
  endtask

  task automatic t_flash();
    for (int i = 0; i < 4; i++) begin
      meas.cell_mv <= 16'h0ed7 + 16'(i > 2 ? 2 : i);
      nv_wr_req <= (i < 3);
      @(posedge clk);
      @(posedge clk);
      chk({15'h0000, nv_wr_en}, {15'h0000, i == 1 || i == 2});
    end
    nv_wr_req <= 1'b0;
    meas.cell_mv <= 16'h0ed8;
  endtask

  task automatic t_wake();
    for (int c = 0; c < 8; c++) begin
      wake_cfg <= gwcpc_pkg::gwcpc_wake_cfg_t'(c[2:0]);
      if (sleeping !== 1'b1) begin
        sleep_in(16'h0000);
        wait_for(0, 1'b1);
      end
      wait_for(1, 1'b0);
      drive(c[0], (TH[c] == 16'h0000) ? 16'h4e20 : TH[c]);
      seen(3, 4, 1'b0);
      if (TH[c] != 16'h0000) begin
        drive(c[0], TH[c] + 16'h0001);
        seen(3, 4, 1'b1);
        drive(c[0], 16'h0000);
        wait_for(0, 1'b0);
      end
    end
  endtask

  task automatic t_cal_temp();
    for (int i = 0; i < 4; i++) begin
      meas.temp_c <= TEMPS[i];
      sleep_in(16'h0000);
      seen(1, 3, i == 1 || i == 2);
      wake_up();
    end
    meas.temp_c <= 16'h0019;
  endtask

  task automatic t_offset();
    rate_in <= 16'sh0032;
    sleep_in(16'h012c);
    wait_for(1, 1'b1);
    rate_in <= 16'sh004d;
    repeat (2) @(posedge clk);
    chk(rate_out, 16'h0032);
    wait_for(1, 1'b0);
    @(posedge clk);
    chk(rate_out, 16'h004d);
    chk(sense_corr, 16'h0000);
    sense_neg_in <= 16'sh0064;
    @(posedge clk);
    @(posedge clk);
    chk(sense_corr, 16'hff9c);
    wake_up();
  endtask

  task automatic t_cal_events();
    sleep_in(16'h012c);
    wait_for(1, 1'b1);
    meas.cell_mv <= 16'h0eb7;
    seen(4, 4, 1'b1);
    meas.cell_mv <= 16'h0ed8;
    wait_for(1, 1'b0);
    wake_up();
    meas.cell_mv <= 16'h0fd8;
    seen(1, 4, 1'b1);
    wait_for(1, 1'b0);
  endtask

  task automatic t_insert(input logic [15:0] z, input logic bad, input logic [7:0] st,
                          input logic [15:0] prof);
    pack_inserted <= 1'b0;
    meas_z <= z;
    repeat (2) @(posedge clk);
    pack_inserted <= 1'b1;
    repeat (3) @(posedge clk);
    chk({12'h000, init_flags, battery_good_out_n}, 16'h0001);
    ocv_ready <= 1'b1;
    ocv_bad <= bad;
    @(posedge clk);
    ocv_ready <= 1'b0;
    ocv_bad <= ~bad;
    wait_for(2, 1'b1);
    chk({12'h000, init_flags, battery_good_out_n}, {12'h000, 1'b1, bad, 2'b10});
    chk({8'h00, soc}, {8'h00, soc_lookup});
    chk(active_prof, prof);
    read_cmd(8'h6a, 1, 1'b1, st);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    meas_valid = 1'b1;
    {sleep_entry, nv_wr_req, pack_inserted, ocv_ready, ocv_bad, def_wr, prof_upd_wr} = 7'h00;
    wake_cfg = gwcpc_pkg::gwcpc_wake_cfg_t'(3'h0);
    flash_ok_mv = 16'h0ed8;
    sleep_ma = 16'h0032;
    open_circuit_voltage = 16'h0f00;
    {meas_z, def_data, prof_upd_data} = 48'h0;
    {sense_pos_in, sense_neg_in, rate_in} = 48'h0;
    soc_lookup = 8'h5a;
    meas = '{cell_mv: 16'h0ed8, temp_c: 16'h0019, avg_ma: 16'h000a};
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    def_wr <= 1'b1;
    def_data <= 16'h0100;
    @(posedge clk);
    def_wr <= 1'b0;
    read_cmd(8'h6a, 0, 1'b1, 8'h00);
    read_cmd(8'h6b, 2, 1'b0, 8'h00);
    wait_for(1, 1'b0);
    t_flash();
    t_wake();
    t_cal_temp();
    t_offset();
    t_cal_events();
    t_insert(16'h0100, 1'b0, 8'h00, 16'h0100);
    prof_upd_wr <= 1'b1;
    prof_upd_data <= 16'h0300;
    @(posedge clk);
    prof_upd_wr <= 1'b0;
    @(posedge clk);
    chk(active_prof, 16'h0300);
    t_insert(16'h0500, 1'b1, 8'h01, 16'h0100);
    t_insert(16'h0305, 1'b0, 8'h00, 16'h0300);
    t_insert(16'h0100, 1'b0, 8'h01, 16'h0100);
    finish_test();
  end
endmodule
